/* include/rw_pkg.sv */
/*
  constants, types and register map of the reset and watchdog block.
  assumes a 50 MHz core clock and an AXI4-Lite master with 32-bit data.
*/
// Summary of operation
// - core stays in reset while external reset pin is low, in any mode.
// - internal reset extends the pin reset with a stabilisation delay.
// - pin reset in run or wait halts core, pulls up I/O, restarts oscillator.
// - pin reset in stop starts oscillator; init follows pin release and delay.
// - power-on detection holds reset with pulled-up inputs and no execution.
// - after power-on, count stabilisation delay, then run initialisation at once.
// - unrefreshed watchdog asserts internal reset, which reinitialises the watchdog.
// - watchdog reset restarts exactly like pin reset, delay included.
// - low-voltage indication holds static reset; hysteresis lives in the detector.
// - any internal reset source drives the external reset pin low.
// - leaving reset clears the stack and loads pc with the reset vector.
// - reset sets non-maskable mode; return from interrupt reverts, pending served first.
// - reset clears oscillator, memory, port, interrupt option and timer control registers.
// - reset loads timer ff, prescaler 7f, watchdog fe, converter control 40.
// - watchdog resets device when downcounter reaches zero unless reloaded.
// - software activation: disabled until activate bit set, then only reset disables.
// - stop mode is entered normally while watchdog is disabled.
// - hardware activation without pin-gated stop: always on, stop acts as wait.
// - pin-gated stop: nmi low means wait; nmi high freezes counter and stops.
// - interrupt leaving stop lets the frozen counter resume decrementing.
// - watchdog counter clocked from internal clock divided by twelve.
// - software reset bit resets on falling to zero; timer msb when disabled.
// - countdown bits reversed: register bit 7 is lsb, bit 2 is msb.
// - timeout spans 3072 to 196608 cycles, chosen by six countdown bits.
package rw_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] RW_OFS_STATUS = 8'h00;
  localparam logic [7:0] RW_OFS_WDR = 8'hD8;

  // ==========================================================
  // reset values
  localparam logic [7:0] RW_WDR_RST = 8'hFE;
  localparam logic [7:0] RW_CLR_RST = 8'h00;
  localparam logic [7:0] RW_TCNT_RST = 8'hFF;
  localparam logic [7:0] RW_TPSC_RST = 8'h7F;
  localparam logic [7:0] RW_ADC_RST = 8'h40;
  localparam logic [11:0] RW_RESET_VECTOR = 12'hFFE;

  // ==========================================================
  // watchdog field positions and timing
  localparam int RW_WDR_C_BIT = 0;
  localparam int RW_WDR_SR_BIT = 1;
  localparam int RW_WDR_T_LO = 2;
  localparam int RW_DIV_INT = 12;
  localparam int RW_STEP_TICKS = 256;
  localparam int RW_WD_MIN_CYCLES = 3072;
  localparam int RW_WD_MAX_CYCLES = 196608;
  localparam int RW_STAB_CYCLES = 2048;

  // ==========================================================
  // types
  typedef struct packed {
    logic [3:0] cause;
    logic nmi_mode;
    logic wait_mode;
    logic stop_mode;
    logic core_reset;
  } rw_status_t;

  typedef struct packed {
    logic pin;
    logic por;
    logic low_voltage_detector;
    logic wdog;
  } rw_cause_t;

endpackage : rw_pkg

/* rtl/rw_reset_watchdog.sv */
/*
  reset merger, stabilisation delay, init sequence and digital watchdog.
  assumes synchronous inputs, option straps stable during reset, and a
  testbench that resolves the open-drain reset pin from reset_pin_oe_n_o.
*/
`timescale 1ns/100ps
module rw_reset_watchdog #(
  parameter int STAB_CYCLES = rw_pkg::RW_STAB_CYCLES,
  parameter int DIV_INT = rw_pkg::RW_DIV_INT,
  parameter int STEP_TICKS = rw_pkg::RW_STEP_TICKS
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reset sources and pin
  input wire logic reset_pin_n_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_n_o,
  input wire logic por_i,
  input wire logic low_voltage_detector_i,
  // option straps
  input wire logic opt_hw_watchdog_i,
  input wire logic opt_ext_stop_i,
  // core side
  input wire logic nmi_pin_i,
  input wire logic stop_instr_i,
  input wire logic wait_instr_i,
  input wire logic wake_irq_i,
  input wire logic return_from_interrupt_i,
  input wire logic irq_pending_i,
  output logic core_reset_o,
  output logic io_pullup_input_o,
  output logic osc_restart_o,
  output logic stop_mode_o,
  output logic wait_mode_o,
  output logic nmi_mode_o,
  output logic stack_clear_o,
  output logic pc_load_o,
  output logic [11:0] pc_vector_o,
  output logic periph_init_o,
  output logic irq_service_o,
  output logic [7:0] reg_clear_val_o,
  output logic [7:0] timer_count_init_o,
  output logic [7:0] timer_psc_init_o,
  output logic [7:0] adc_ctrl_init_o
);

  // ==========================================================
  // helpers
  function automatic logic [5:0] rw_rev6(input logic [5:0] v);
    logic [5:0] r;
    r = '0;
    for (int i = 0; i < 6; i++)
    begin
      r[i] = v[5 - i];
    end
    return r;
  endfunction : rw_rev6

  typedef enum logic [1:0] {RS_HOLD, RS_DELAY, RS_INIT, RS_RUN} rw_rst_state_t;
  typedef enum logic [1:0] {MD_RUN, MD_WAIT, MD_STOP} rw_mode_t;

  // ==========================================================
  // reset sequencer
  rw_rst_state_t rs_r, rs_nxt;
  logic [$clog2(STAB_CYCLES+1)-1:0] dly_r, dly_nxt;
  logic int_cause_r, int_cause_nxt;
  logic drive_r, drive_nxt;
  logic [3:0] cause_r, cause_nxt;
  logic nmi_mode_r, nmi_mode_nxt;
  logic irq_srv_r, irq_srv_nxt;
  logic init_r, init_nxt;
  logic osc_r, osc_nxt;
  logic hw_wd_r, hw_wd_nxt;
  logic ext_stop_r, ext_stop_nxt;
  logic ext_low;
  logic wd_fire;
  logic any_src;
  logic in_reset;
  rw_pkg::rw_cause_t src;

  // own pin drive is masked so the wired pin does not hold itself low
  assign ext_low = !reset_pin_n_i && !drive_r;
  assign src = '{pin: ext_low, por: por_i, low_voltage_detector: low_voltage_detector_i, wdog: wd_fire};
  assign any_src = |src;
  assign in_reset = (rs_r != RS_RUN) && (rs_r != RS_INIT);

  always_comb
  begin
    rs_nxt = rs_r;
    dly_nxt = dly_r;
    int_cause_nxt = int_cause_r;
    cause_nxt = cause_r;
    nmi_mode_nxt = nmi_mode_r;
    irq_srv_nxt = 1'b0;
    init_nxt = 1'b0;
    osc_nxt = 1'b0;
    hw_wd_nxt = hw_wd_r;
    ext_stop_nxt = ext_stop_r;
    if (any_src)
    begin
      rs_nxt = RS_HOLD;
      dly_nxt = '0;
      cause_nxt = (rs_r == RS_RUN) ? src : (cause_r | src);
      osc_nxt = (rs_r != RS_HOLD);
      if (wd_fire || por_i || low_voltage_detector_i)
      begin
        int_cause_nxt = 1'b1;
      end
    end
    else
    begin
      unique case (rs_r)
        RS_HOLD:
        begin
          rs_nxt = RS_DELAY;
          dly_nxt = '0;
        end
        RS_DELAY:
        begin
          // same delay for every source, watchdog included
          if (dly_r == ($clog2(STAB_CYCLES+1))'(STAB_CYCLES - 1))
          begin
            rs_nxt = RS_INIT;
            init_nxt = 1'b1;
          end
          else
          begin
            dly_nxt = dly_r + 1'b1;
          end
        end
        RS_INIT:
        begin
          rs_nxt = RS_RUN;
          int_cause_nxt = 1'b0;
        end
        RS_RUN:
        begin
          rs_nxt = RS_RUN;
        end
      endcase
    end
    // straps are captured while the core sits in reset
    if (in_reset)
    begin
      hw_wd_nxt = opt_hw_watchdog_i;
      ext_stop_nxt = opt_ext_stop_i;
    end
    if (rs_r == RS_INIT)
    begin
      nmi_mode_nxt = 1'b1;
    end
    else if (return_from_interrupt_i && nmi_mode_r && rs_r == RS_RUN)
    begin
      nmi_mode_nxt = 1'b0;
      irq_srv_nxt = irq_pending_i;
    end
  end

  // internal sources hold the pin low through hold and delay
  assign drive_nxt = por_i || low_voltage_detector_i || wd_fire
    || (int_cause_r && rs_r != RS_RUN && rs_r != RS_INIT);

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rs_r <= RS_HOLD;
      dly_r <= '0;
      int_cause_r <= 1'b1;
      drive_r <= 1'b1;
      cause_r <= 4'h4;
      nmi_mode_r <= 1'b0;
      irq_srv_r <= 1'b0;
      init_r <= 1'b0;
      osc_r <= 1'b0;
      hw_wd_r <= 1'b0;
      ext_stop_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rs_r <= rs_nxt;
      dly_r <= dly_nxt;
      int_cause_r <= int_cause_nxt;
      drive_r <= drive_nxt;
      cause_r <= cause_nxt;
      nmi_mode_r <= nmi_mode_nxt;
      irq_srv_r <= irq_srv_nxt;
      init_r <= init_nxt;
      osc_r <= osc_nxt;
      hw_wd_r <= hw_wd_nxt;
      ext_stop_r <= ext_stop_nxt;
    end
  end

  // ==========================================================
  // run, wait and stop
  rw_mode_t md_r, md_nxt;
  logic wd_active;

  always_comb
  begin
    md_nxt = md_r;
    if (rs_r != RS_RUN)
    begin
      md_nxt = MD_RUN;
    end
    else if (md_r != MD_RUN)
    begin
      if (wake_irq_i)
      begin
        md_nxt = MD_RUN;
      end
    end
    else if (stop_instr_i)
    begin
      if (!wd_active)
      begin
        md_nxt = MD_STOP;
      end
      else if (ext_stop_r && nmi_pin_i)
      begin
        md_nxt = MD_STOP;
      end
      else
      begin
        md_nxt = MD_WAIT;
      end
    end
    else if (wait_instr_i)
    begin
      md_nxt = MD_WAIT;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      md_r <= MD_RUN;
    end
    else if (clk_en_i)
    begin
      md_r <= md_nxt;
    end
  end

  // ==========================================================
  // watchdog: physical counter {sr, t5..t0}, enable bit
  logic [6:0] cnt_r, cnt_nxt;
  logic en_r, en_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic [$clog2(STEP_TICKS)-1:0] step_r, step_nxt;
  logic wd_tick;
  logic wr_fire;
  logic wdr_write;
  logic [7:0] wdata;

  assign wd_active = en_r || hw_wd_r;
  // stop freezes the divider too, so the count resumes where it left
  assign wd_tick = (rs_r == RS_RUN) && (md_r != MD_STOP)
    && (pre_r == 4'(DIV_INT - 1))
    && (step_r == ($clog2(STEP_TICKS))'(STEP_TICKS - 1));
  assign wdata = s_axi_wdata[7:0];

  always_comb
  begin
    cnt_nxt = cnt_r;
    en_nxt = en_r;
    pre_nxt = pre_r;
    step_nxt = step_r;
    wr_fire = 1'b0;
    if (rs_r != RS_RUN)
    begin
      // any internal reset reinitialises the watchdog
      cnt_nxt = rw_pkg::RW_WDR_RST[7:1];
      en_nxt = 1'b0;
      pre_nxt = '0;
      step_nxt = '0;
    end
    else if (wdr_write)
    begin
      cnt_nxt = {wdata[rw_pkg::RW_WDR_SR_BIT], rw_rev6(wdata[7:rw_pkg::RW_WDR_T_LO])};
      en_nxt = en_r || wdata[rw_pkg::RW_WDR_C_BIT];
      pre_nxt = '0;
      step_nxt = '0;
      wr_fire = (en_nxt || hw_wd_r) && !wdata[rw_pkg::RW_WDR_SR_BIT];
    end
    else if (md_r != MD_STOP)
    begin
      if (pre_r == 4'(DIV_INT - 1))
      begin
        pre_nxt = '0;
        step_nxt = step_r + 1'b1;
      end
      else
      begin
        pre_nxt = pre_r + 1'b1;
      end
      if (wd_tick)
      begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  // disabled, the counter just wraps as a seven-bit timer
  assign wd_fire = (wd_tick && wd_active && cnt_r == 7'h40) || wr_fire;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_r <= rw_pkg::RW_WDR_RST[7:1];
      en_r <= 1'b0;
      pre_r <= '0;
      step_r <= '0;
    end
    else if (clk_en_i)
    begin
      cnt_r <= cnt_nxt;
      en_r <= en_nxt;
      pre_r <= pre_nxt;
      step_r <= step_nxt;
    end
  end

  // ==========================================================
  // axi4-lite slave, address and data taken together
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_go;
  logic rd_go;
  rw_pkg::rw_status_t stat;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  // writes during reset are answered but dropped
  assign wdr_write = wr_go && s_axi_awaddr == rw_pkg::RW_OFS_WDR && s_axi_wstrb[0];
  assign stat = '{cause: cause_r, nmi_mode: nmi_mode_r, wait_mode: md_r == MD_WAIT,
    stop_mode: md_r == MD_STOP, core_reset: rs_r != RS_RUN};

  always_comb
  begin
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (wr_go)
    begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (s_axi_awaddr == rw_pkg::RW_OFS_WDR) ? 2'h0 : 2'h2;
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
    if (rd_go)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'h0;
      rdata_nxt = '0;
      if (s_axi_araddr == rw_pkg::RW_OFS_WDR)
      begin
        rdata_nxt[7:0] = {rw_rev6(cnt_r[5:0]), cnt_r[6], wd_active};
      end
      else if (s_axi_araddr == rw_pkg::RW_OFS_STATUS)
      begin
        rdata_nxt[7:0] = stat;
      end
      else
      begin
        rresp_nxt = 2'h2;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
    end
    else if (clk_en_i)
    begin
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ==========================================================
  // outputs
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n_o = !drive_r;
  assign core_reset_o = rs_r != RS_RUN;
  assign io_pullup_input_o = rs_r != RS_RUN;
  assign osc_restart_o = osc_r;
  assign stop_mode_o = md_r == MD_STOP;
  assign wait_mode_o = md_r == MD_WAIT;
  assign nmi_mode_o = nmi_mode_r;
  assign stack_clear_o = init_r;
  assign pc_load_o = init_r;
  assign pc_vector_o = rw_pkg::RW_RESET_VECTOR;
  assign periph_init_o = init_r || rs_r != RS_RUN;
  assign irq_service_o = irq_srv_r;
  assign reg_clear_val_o = rw_pkg::RW_CLR_RST;
  assign timer_count_init_o = rw_pkg::RW_TCNT_RST;
  assign timer_psc_init_o = rw_pkg::RW_TPSC_RST;
  assign adc_ctrl_init_o = rw_pkg::RW_ADC_RST;

endmodule : rw_reset_watchdog

/* bench/rw_reset_watchdog_props.sv */
/*
  port checks of the reset and watchdog block.
  assumes clk_en_i held high and the wired reset pin resolved outside.
*/
`timescale 1ns/100ps
module rw_props #(
  parameter int STAB_CYCLES = 4
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic reset_pin_n_i,
  input wire logic reset_pin_oe_n_o,
  input wire logic por_i,
  input wire logic low_voltage_detector_i,
  input wire logic opt_hw_watchdog_i,
  input wire logic opt_ext_stop_i,
  input wire logic nmi_pin_i,
  input wire logic stop_instr_i,
  input wire logic wake_irq_i,
  input wire logic return_from_interrupt_i,
  input wire logic irq_pending_i,
  input wire logic core_reset_o,
  input wire logic io_pullup_input_o,
  input wire logic osc_restart_o,
  input wire logic periph_init_o,
  input wire logic stop_mode_o,
  input wire logic wait_mode_o,
  input wire logic nmi_mode_o,
  input wire logic stack_clear_o,
  input wire logic pc_load_o,
  input wire logic [11:0] pc_vector_o,
  input wire logic irq_service_o,
  input wire logic [7:0] reg_clear_val_o,
  input wire logic [7:0] timer_count_init_o
);
  // ==========================================
  // helpers
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic src;
  logic run;
  int quiet_r;
  int quiet_nxt;
  // own pin drive is not an outside request
  assign src = (!reset_pin_n_i && reset_pin_oe_n_o) || por_i || low_voltage_detector_i;
  assign run = !core_reset_o && !stop_mode_o && !wait_mode_o;
  always_comb quiet_nxt = src ? 0 : (quiet_r < 1000 ? quiet_r + 1 : quiet_r);
  always_ff @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
      quiet_r <= 0;
    else
      quiet_r <= quiet_nxt;
  sequence s_init;
    pc_load_o && stack_clear_o && pc_vector_o == 12'hFFE;
  endsequence
  // ==========================================
  // assertions
  a_pin_holds: assert property (!reset_pin_n_i && reset_pin_oe_n_o |=> core_reset_o)
    else $error("pin low without core reset");
  a_lvd_static: assert property (low_voltage_detector_i |=> core_reset_o && !reset_pin_oe_n_o)
    else $error("low supply without reset or pin drive");
  a_por_pullup: assert property (por_i |=> core_reset_o && io_pullup_input_o && !reset_pin_oe_n_o)
    else $error("power-on without reset state");
  a_delay_min: assert property ($fell(core_reset_o) |-> quiet_r >= STAB_CYCLES)
    else $error("reset released before delay");
  a_init_vector: assert property (pc_load_o |-> s_init ##[0:2] (!core_reset_o && nmi_mode_o))
    else $error("init sequence wrong");
  a_return_from_interrupt_clears: assert property (return_from_interrupt_i && run |=> !nmi_mode_o)
    else $error("return kept nmi mode");
  a_return_from_interrupt_service: assert property (return_from_interrupt_i && irq_pending_i && run |=> irq_service_o)
    else $error("pending irq not served");
  a_hw_stop_wait: assert property (stop_instr_i && run && opt_hw_watchdog_i
    && !(opt_ext_stop_i && nmi_pin_i) |=> wait_mode_o && !stop_mode_o)
    else $error("stop not taken as wait");
  a_ext_stop: assert property (stop_instr_i && run && opt_hw_watchdog_i && opt_ext_stop_i
    && nmi_pin_i |=> stop_mode_o)
    else $error("gated stop not entered");
  a_wake_run: assert property (stop_mode_o && wake_irq_i && !src |=> !stop_mode_o)
    else $error("wake left stop mode set");
  a_init_consts: assert property (reg_clear_val_o == 8'h00 && timer_count_init_o == 8'hFF)
    else $error("init constant wrong");
  a_osc_restart: assert property ($rose(core_reset_o) |-> osc_restart_o)
    else $error("reset entered without oscillator restart");
  a_periph_init: assert property (core_reset_o || pc_load_o |-> periph_init_o)
    else $error("peripheral init not held");
endmodule : rw_props

bind rw_reset_watchdog rw_props #(.STAB_CYCLES(STAB_CYCLES)) i_props (.*);

/* bench/rw_supervisor_model.sv */
/*
  board supervisor on the wired reset pin.
  assumes the device pulls the pin only through its low-active enable.
*/
`timescale 1ns/100ps
module rw_supervisor_model (
  input wire logic pull_low_i,
  input wire logic dev_oe_n_i,
  output logic pin_n_o
);
  // built-in pull-up: a released pin reads high
  assign pin_n_o = !pull_low_i && dev_oe_n_i;
endmodule : rw_supervisor_model

/* bench/tb_reset_and_watchdog.sv */
/*
  self-checking bench of the reset and watchdog block.
  assumes short delay and step parameters so watchdog periods stay small.
*/
`timescale 1ns/100ps
module tb_reset_and_watchdog;
  localparam int STAB = 4;
  localparam int STEP = 48;
  logic clock_i, arst_n_i, clk_en_i, pull_low;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rd;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic reset_pin_n_i, reset_pin_o, reset_pin_oe_n_o, por_i, low_voltage_detector_i;
  logic opt_hw_watchdog_i, opt_ext_stop_i, nmi_pin_i, stop_instr_i, wait_instr_i, wake_irq_i;
  logic return_from_interrupt_i, irq_pending_i, core_reset_o, io_pullup_input_o, osc_restart_o;
  logic stop_mode_o, wait_mode_o, nmi_mode_o, stack_clear_o, pc_load_o, periph_init_o;
  logic irq_service_o;
  logic [11:0] pc_vector_o;
  logic [7:0] reg_clear_val_o, timer_count_init_o, timer_psc_init_o, adc_ctrl_init_o;
  int fails, checks, seed, n, t;

  rw_reset_watchdog #(.STAB_CYCLES(STAB), .STEP_TICKS(4)) i_dut (.*);
  rw_supervisor_model i_sup (.pull_low_i(pull_low), .dev_oe_n_i(reset_pin_oe_n_o),
    .pin_n_o(reset_pin_n_i));

  always #10 clock_i = !clock_i;

  // ==========================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  function automatic logic pick(input int w);
    case (w)
      0: return s_axi_awready && s_axi_wready;
      1: return s_axi_bvalid;
      2: return s_axi_arready;
      3: return s_axi_rvalid;
      4: return core_reset_o;
      default: return !core_reset_o;
    endcase
  endfunction : pick

  // polled at the falling edge, so the next rising edge sees the same level
  task automatic wait_for(input int w, input int lim);
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end while (!pick(w) && n < lim);
    if (!pick(w))
    begin
      fails++;
      test_done();
    end
  endtask : wait_for

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= ($random(seed) & 32'hFFFFFF00) | {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wait_for(0, 50);
    @(posedge clock_i);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wait_for(1, 50);
    resp = s_axi_bresp;
    @(posedge clock_i);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_for(2, 50);
    @(posedge clock_i);
    s_axi_arvalid <= 1'b0;
    wait_for(3, 50);
    rd = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    @(posedge clock_i);
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic pulse(input int w);
    @(posedge clock_i);
    case (w)
      0: stop_instr_i <= 1'b1;
      1: wake_irq_i <= 1'b1;
      3: wait_instr_i <= 1'b1;
      default: return_from_interrupt_i <= 1'b1;
    endcase
    @(posedge clock_i);
    stop_instr_i <= 1'b0;
    wait_instr_i <= 1'b0;
    wake_irq_i <= 1'b0;
    return_from_interrupt_i <= 1'b0;
    @(negedge clock_i);
  endtask : pulse

  task automatic pin_rst(input int len);
    @(posedge clock_i);
    pull_low <= 1'b1;
    repeat (len) @(posedge clock_i);
    pull_low <= 1'b0;
    wait_for(5, 200);
  endtask : pin_rst

  function automatic logic [5:0] rev6(input logic [5:0] v);
    for (int i = 0; i < 6; i++)
      rev6[i] = v[5 - i];
  endfunction : rev6

  // ==========================================
  // sequence
  initial
  begin
    {clock_i, arst_n_i, pull_low, por_i, low_voltage_detector_i} = 5'h00;
    {opt_hw_watchdog_i, opt_ext_stop_i, nmi_pin_i, stop_instr_i, wait_instr_i} = 5'h00;
    {wake_irq_i, return_from_interrupt_i, irq_pending_i, clk_en_i} = 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h000000000000F;
    seed = 32'h742C;
    fails = 0;
    checks = 0;
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    wait_for(5, 100);
    rdr(8'hD8);
    check(rd, 8'hFE);
    rdr(8'h00);
    check(rd[7:3], 5'h09);
    rdr(8'h44);
    check(resp, 2'h2);
    wr(8'h44, 8'h00);
    check(resp, 2'h2);
    check({timer_psc_init_o, adc_ctrl_init_o}, 16'h7F40);
    irq_pending_i <= 1'b1;
    pulse(2);
    check(nmi_mode_o, 1'b0);
    $display("test reset_state done");
    for (int i = 0; i < 4; i++)
    begin
      pin_rst(1 + ($random(seed) & 15));
      check(n >= STAB + 1 && n <= STAB + 3, 1'b1);
      rdr(8'h00);
      check(rd[7:4], 4'h8);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock_i);
      {por_i, low_voltage_detector_i} <= k ? 2'b10 : 2'b01;
      repeat (5 + ($random(seed) & 31)) @(negedge clock_i);
      check({reset_pin_o, reset_pin_oe_n_o}, 2'b00);
      @(posedge clock_i);
      {por_i, low_voltage_detector_i} <= 2'b00;
      wait_for(5, 200);
      check(n >= STAB + 1, 1'b1);
      rdr(8'h00);
      check(rd[7:4], k ? 4'h4 : 4'h2);
    end
    $display("test sources done");
    wr(8'hD8, 8'hFE);
    pulse(0);
    check(stop_mode_o, 1'b1);
    pulse(1);
    check(stop_mode_o, 1'b0);
    pulse(3);
    check(wait_mode_o, 1'b1);
    pin_rst(1 + ($random(seed) & 3));
    check(wait_mode_o, 1'b0);
    wr(8'hD8, 8'hFF);
    wr(8'hD8, 8'hFE);
    rdr(8'hD8);
    check(rd[0], 1'b1);
    pulse(0);
    check(wait_mode_o, 1'b1);
    pulse(1);
    wr(8'hD8, 8'hFD);
    wait_for(5, 200);
    rdr(8'h00);
    check(rd[7:4], 4'h1);
    rdr(8'hD8);
    check(rd, 8'hFE);
    $display("test soft_watchdog done");
    opt_hw_watchdog_i <= 1'b1;
    pin_rst(2);
    for (int i = 0; i < 3; i++)
    begin
      t = i == 0 ? 63 : $random(seed) & 7;
      wr(8'hD8, {rev6(t[5:0]), 2'b10});
      wait_for(4, 4000);
      check(n >= (t + 1) * STEP - 3 && n <= (t + 1) * STEP + 3, 1'b1);
      wait_for(5, 200);
      rdr(8'h00);
      check(rd[7:4], 4'h1);
    end
    repeat (4)
    begin
      wr(8'hD8, {rev6(6'h01), 2'b10});
      pulse(0);
      check(wait_mode_o, 1'b1);
      pulse(1);
      repeat (50) @(negedge clock_i);
    end
    check(core_reset_o, 1'b0);
    $display("test hard_watchdog done");
    opt_ext_stop_i <= 1'b1;
    nmi_pin_i <= 1'b1;
    pin_rst(2);
    wr(8'hD8, {rev6(6'h01), 2'b10});
    pulse(0);
    check(stop_mode_o, 1'b1);
    repeat (300) @(negedge clock_i);
    check(core_reset_o, 1'b0);
    check(stop_mode_o, 1'b1);
    pulse(1);
    wait_for(4, 150);
    check(core_reset_o, 1'b1);
    wait_for(5, 200);
    @(posedge clock_i);
    nmi_pin_i <= 1'b0;
    wr(8'hD8, {rev6(6'h01), 2'b10});
    pulse(0);
    check(wait_mode_o, 1'b1);
    pulse(1);
    $display("test ext_stop done");
    test_done();
  end

  // a hang counts as a mismatch
  initial
  begin
    #2000000;
    fails++;
    test_done();
  end
endmodule : tb_reset_and_watchdog
